// [rtl/pbm_params.svh]
// Constants for the phase and burst manager: timing counts and reset values.
// Assumes a 100 MHz core clock; included by the package and the top module.
`ifndef PBM_PARAMS_SVH
`define PBM_PARAMS_SVH
`define PBM_CLK_MHZ 100
`define PBM_SHED_HALF_CYCLES 14
`define PBM_RAMP_CYCLES 8
`define PBM_RAMP_STEP_W 4
`define PBM_TON_W 12
`define PBM_RST_TON 12'h000
`define PBM_SYNC_RST 10'h040
`endif

// [rtl/pbm_pkg.sv]
// Types shared by the phase and burst manager.
// Assumes the params header sits next to this file.
`include "pbm_params.svh"
package pbm_pkg;
  // Burst sequencer states, one-hot
  typedef enum logic [4:0] {
    PBM_STANDBY = 5'h01,
    PBM_SOFT_START = 5'h02,
    PBM_RUN = 5'h04,
    PBM_SOFT_OFF = 5'h08,
    PBM_IDLE = 5'h10
  } pbm_state_t;
  localparam int PBM_SOFT_ON_FLAG = 1;
endpackage : pbm_pkg

// [rtl/pbm_phase_burst_manager.sv]
// Light-load mode manager for a two-channel interleaved boost PFC controller.
// Assumes analog comparators outside feed raw level bits; one 100 MHz clock.
`timescale 1ns/1ps
`include "pbm_params.svh"
module pbm_phase_burst_manager
  import pbm_pkg::*;
#(
  parameter int TON_W = `PBM_TON_W,
  parameter int SHED_HALF_CYCLES = `PBM_SHED_HALF_CYCLES,
  parameter int RAMP_CYCLES = `PBM_RAMP_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic BELOW_SHED_IN,       // Control below shed threshold
  input wire logic ABOVE_SHED_HYST_IN,  // Control above shed threshold plus hysteresis
  input wire logic BELOW_BURST_IN,      // Control below burst threshold
  input wire logic ABOVE_BURST_HYST_IN, // Control above burst threshold plus hysteresis
  input wire logic SHED_BELOW_BURST_IN, // Shed threshold lies below burst threshold
  input wire logic LINE_HIGH_IN,        // Line sense peak above 3.5 V
  input wire logic SENSE_LOW_IN,        // Output sense pulled to ground
  input wire logic SENSE_REG_OK_IN,     // Output sense above 95% of regulation
  input wire logic HALF_CYCLE_IN,       // Pulse per rectified line half cycle
  input wire logic SW_CYCLE_IN,         // Pulse per switching cycle
  input wire logic [TON_W-1:0] TON_CMD_IN,  // Dual-phase on-time from control level
  input wire logic [TON_W-1:0] TON_MAX_IN,  // Dual-phase maximum on-time
  output logic [TON_W-1:0] TON_A_OUT,
  output logic GATE_A_EN_OUT,
  output logic GATE_DRIVE_SECOND_EN_OUT,
  output logic SINGLE_PHASE_OUT,
  output logic SHED_RANGE_CURRENT_OUT,
  output logic BURST_RANGE_CURRENT_OUT,
  output logic COMP_DISCHARGE_OUT,
  output logic STANDBY_OUT
);

  localparam int CNT_W = $clog2(SHED_HALF_CYCLES + 1);
  localparam int RMP_W = $clog2(RAMP_CYCLES + 1);
  localparam int NSYNC = 10;

  // Two-flop synchronisers for every asynchronous comparator and pulse
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  assign raw = {SW_CYCLE_IN, HALF_CYCLE_IN, SENSE_REG_OK_IN, SENSE_LOW_IN, LINE_HIGH_IN,
                SHED_BELOW_BURST_IN, ABOVE_BURST_HYST_IN, BELOW_BURST_IN,
                ABOVE_SHED_HYST_IN, BELOW_SHED_IN};
  // The disable input resets to its pulled-low level, so leaving reset
  // cannot flash a soft-start before the real pin value arrives
  localparam logic [NSYNC-1:0] SYNC_RST = `PBM_SYNC_RST;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          sync_a[gi] <= SYNC_RST[gi];
          sync_b[gi] <= SYNC_RST[gi];
        end else begin
          sync_a[gi] <= raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic below_shed, above_shed_hyst, below_burst, above_burst_hyst, shed_lt_burst;
  logic line_high, sense_low, sense_ok, half_lvl, sw_lvl;
  assign {sw_lvl, half_lvl, sense_ok, sense_low, line_high, shed_lt_burst,
          above_burst_hyst, below_burst, above_shed_hyst, below_shed} = sync_b;

  // Edge detect the synchronised pulses; slow inputs are stretched levels
  logic half_d, sw_d;
  logic half_tick, sw_tick;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      half_d <= 1'b0;
      sw_d <= 1'b0;
    end else begin
      half_d <= half_lvl;
      sw_d <= sw_lvl;
    end
  end
  assign half_tick = half_lvl & ~half_d;
  assign sw_tick = sw_lvl & ~sw_d;

  // Burst sequencer
  pbm_state_t state, next_state;
  logic [RMP_W-1:0] ramp;
  logic soft_on;
  logic ramp_done;
  assign ramp_done = (ramp == RMP_W'(RAMP_CYCLES));

  always_comb begin
    next_state = state;
    case (state)
      PBM_STANDBY: begin
        if (!sense_low) next_state = PBM_SOFT_START;
      end
      PBM_SOFT_START: begin
        if (sense_low) next_state = PBM_STANDBY;
        else if (sense_ok) next_state = PBM_RUN;
      end
      PBM_RUN: begin
        if (sense_low) next_state = PBM_STANDBY;
        else if (below_burst) next_state = PBM_SOFT_OFF;
      end
      PBM_SOFT_OFF: begin
        if (sense_low) next_state = PBM_STANDBY;
        else if (ramp_done) next_state = PBM_IDLE;
      end
      PBM_IDLE: begin
        if (sense_low) next_state = PBM_STANDBY;
        else if (above_burst_hyst) next_state = PBM_RUN;
      end
      default: next_state = PBM_STANDBY;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) state <= PBM_STANDBY;
    else state <= next_state;
  end

  // Ramp counter: counts switching cycles in soft-off and soft-on
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ramp <= '0;
      soft_on <= 1'b0;
    end else if (state != next_state) begin
      ramp <= '0;
      soft_on <= (state == PBM_IDLE) && (next_state == PBM_RUN);
    end else if ((state == PBM_SOFT_OFF || soft_on) && sw_tick && !ramp_done) begin
      ramp <= ramp + RMP_W'(1);
    end else if (soft_on && ramp_done) begin
      soft_on <= 1'b0;
    end
  end

  // Half-cycle filter for single-phase entry
  logic [CNT_W-1:0] half_cnt;
  logic filt_single;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      half_cnt <= '0;
      filt_single <= 1'b0;
    end else if (state == PBM_STANDBY || state == PBM_SOFT_START) begin
      half_cnt <= '0;
      filt_single <= 1'b0;
    end else if (above_shed_hyst) begin
      half_cnt <= '0;
      filt_single <= 1'b0;
    end else if (!below_shed) begin
      half_cnt <= '0;
    end else if (half_tick && !filt_single) begin
      if (half_cnt == CNT_W'(SHED_HALF_CYCLES - 1)) filt_single <= 1'b1;
      else half_cnt <= half_cnt + CNT_W'(1);
    end
  end

  // Phase decision; ramps with shed below burst and low burst comparator override the filter
  logic ramping, single;
  assign ramping = (state == PBM_SOFT_OFF) || soft_on;
  always_comb begin
    single = 1'b0;
    if (state == PBM_RUN || state == PBM_SOFT_OFF || state == PBM_IDLE) begin
      single = filt_single || below_burst || (ramping && shed_lt_burst);
    end
  end

  // On-time shaping: doubled and clamped single, ramped in burst edges
  logic [TON_W:0] dbl;
  logic [TON_W-1:0] base, scaled;
  logic [TON_W+RMP_W-1:0] prod;
  always_comb begin
    dbl = {TON_CMD_IN, 1'b0};
    if (single) begin
      // Doubling is bounded so the inductor never sees more than dual max
      if (dbl > {1'b0, TON_MAX_IN}) base = TON_MAX_IN;
      else base = dbl[TON_W-1:0];
    end else begin
      base = TON_CMD_IN;
    end
    if (state == PBM_SOFT_OFF) begin
      prod = base * (RMP_W'(RAMP_CYCLES) - ramp);
    end else if (soft_on && !ramp_done) begin
      // Once the count is reached the on-time holds at full scale; a ninth step would overshoot
      prod = base * (ramp + RMP_W'(1));
    end else begin
      prod = base * RMP_W'(RAMP_CYCLES);
    end
    scaled = TON_W'(prod / (TON_W+RMP_W)'(RAMP_CYCLES));
  end

  // Registered outputs
  logic switching;
  logic drive_on;
  assign switching = (state == PBM_SOFT_START) || (state == PBM_RUN) || (state == PBM_SOFT_OFF);
  // Gates drop in the same step as standby, so a disable never leaves a pulse running
  assign drive_on = switching && (next_state != PBM_STANDBY);
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TON_A_OUT <= `PBM_RST_TON;
      GATE_A_EN_OUT <= 1'b0;
      GATE_DRIVE_SECOND_EN_OUT <= 1'b0;
      SINGLE_PHASE_OUT <= 1'b0;
    end else begin
      TON_A_OUT <= drive_on ? scaled : TON_W'(0);
      GATE_A_EN_OUT <= drive_on;
      GATE_DRIVE_SECOND_EN_OUT <= drive_on && !single;
      SINGLE_PHASE_OUT <= single;
    end
  end

  // Range currents and standby outputs
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SHED_RANGE_CURRENT_OUT <= 1'b0;
      BURST_RANGE_CURRENT_OUT <= 1'b0;
      COMP_DISCHARGE_OUT <= 1'b1;
      STANDBY_OUT <= 1'b1;
    end else begin
      SHED_RANGE_CURRENT_OUT <= line_high;
      BURST_RANGE_CURRENT_OUT <= line_high;
      COMP_DISCHARGE_OUT <= (next_state == PBM_STANDBY);
      STANDBY_OUT <= (next_state == PBM_STANDBY);
    end
  end

  // Checks
  a_second_off_single: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    SINGLE_PHASE_OUT |-> !GATE_DRIVE_SECOND_EN_OUT)
    else $error("second gate on in single phase");
  a_ton_clamp: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (SINGLE_PHASE_OUT && $stable(TON_MAX_IN)) |-> TON_A_OUT <= $past(TON_MAX_IN))
    else $error("single on-time above clamp");
  a_soft_start_dual: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    $past(state == PBM_SOFT_START) |-> !SINGLE_PHASE_OUT)
    else $error("single phase in soft-start");
  a_filter_count: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    $rose(filt_single) |-> $past(half_cnt) == CNT_W'(SHED_HALF_CYCLES - 1))
    else $error("filter ended early");
  a_return_dual: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (above_shed_hyst && state == PBM_RUN && !below_burst) |=> !filt_single)
    else $error("return to dual delayed");
  a_counter_clear: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (!below_shed && state == PBM_RUN) |=> half_cnt == '0)
    else $error("half counter not cleared");
  a_burst_force: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (below_burst && state == PBM_RUN) |=> SINGLE_PHASE_OUT)
    else $error("burst did not force single");
  a_soft_off_len: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_SOFT_OFF && next_state == PBM_IDLE) |-> ramp == RMP_W'(RAMP_CYCLES))
    else $error("soft-off too short");
  a_idle_gates_off: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    $past(state == PBM_IDLE) |-> !GATE_A_EN_OUT)
    else $error("gate on in idle");
  a_idle_exit: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_IDLE && !above_burst_hyst && !sense_low) |=> state == PBM_IDLE)
    else $error("idle left without hysteresis");
  a_range_current: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    line_high |=> SHED_RANGE_CURRENT_OUT && BURST_RANGE_CURRENT_OUT)
    else $error("range current missing");
  a_disable_standby: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    sense_low |=> STANDBY_OUT && COMP_DISCHARGE_OUT && !GATE_A_EN_OUT)
    else $error("disable not honoured");
  a_release_start: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_STANDBY && !sense_low) |=> state == PBM_SOFT_START)
    else $error("no soft-start after release");
  a_ramp_single: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (ramping && shed_lt_burst && state != PBM_SOFT_START) |=> SINGLE_PHASE_OUT)
    else $error("ramp not single");
  a_soft_start_end: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_SOFT_START && !sense_ok) |=> state != PBM_RUN)
    else $error("soft-start ended early");
  // Ramp shaping, range current, disable, hold, on-time, idle and soft-start checks
  a_soft_on_bound: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    soft_on |-> scaled <= base)
    else $error("soft-on overshoots commanded on-time");
  a_soft_off_fall: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_SOFT_OFF) |-> scaled <= base)
    else $error("soft-off on-time above base");
  a_soft_on_start: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_IDLE && next_state == PBM_RUN) |=> soft_on && ramp == '0)
    else $error("soft-on not started");
  a_soft_on_end: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (soft_on && ramp_done) |=> !soft_on)
    else $error("soft-on did not end");
  a_burst_current: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    !line_high |=> !SHED_RANGE_CURRENT_OUT && !BURST_RANGE_CURRENT_OUT)
    else $error("range current without high line");
  a_disable_second: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    sense_low |=> !GATE_DRIVE_SECOND_EN_OUT && TON_A_OUT == '0)
    else $error("second gate or on-time left on in disable");
  a_standby_hold: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_STANDBY && sense_low) |=> state == PBM_STANDBY && STANDBY_OUT)
    else $error("standby left while disabled");
  a_dual_on_time: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_RUN && !single && !soft_on && !sense_low)
    |=> TON_A_OUT == $past(TON_CMD_IN))
    else $error("dual on-time not restored");
  a_single_hold: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (filt_single && !above_shed_hyst && state == PBM_RUN) |=> filt_single)
    else $error("single phase left below hysteresis");
  a_idle_ton_zero: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_IDLE) |=> TON_A_OUT == '0)
    else $error("on-time left in idle");
  a_idle_second_off: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    $past(state == PBM_IDLE) |-> !GATE_DRIVE_SECOND_EN_OUT)
    else $error("second gate on in idle");
  a_soft_start_both: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    (state == PBM_SOFT_START && !sense_low) |=> GATE_DRIVE_SECOND_EN_OUT && GATE_A_EN_OUT)
    else $error("soft-start not dual phase");

  c_shed: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) $rose(filt_single));
  c_idle: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    state == PBM_SOFT_OFF ##1 state == PBM_IDLE);
  c_soft_on: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) $fell(soft_on));
  c_disable: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    state == PBM_RUN ##1 state == PBM_STANDBY);
  c_ramp_single: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
    soft_on && shed_lt_burst && single);

endmodule : pbm_phase_burst_manager

// [verification/pbm_stage_model.sv]
// Model of the two boost power stages seen from the channel A gate enable.
// Assumes one core clock; a switching cycle lasts 8 clocks.
`timescale 1ns/1ps
module pbm_stage_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic gate_a_en_in,
  input wire logic shed_low_in,
  output logic sw_cycle_out,
  output logic shed_below_burst_out
);
  logic [2:0] phase_cnt;
  // The setting network normally keeps the shed level above the burst level
  // The bench may swap the two levels to exercise single-phase ramps
  assign shed_below_burst_out = shed_low_in;
  // Cycle marker only while channel A switches, so a halted stage gives no ticks
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_cnt <= 3'h0;
    end else begin
      phase_cnt <= gate_a_en_in ? phase_cnt + 3'h1 : 3'h0;
    end
  end
  // Two clocks high, six low: meets the marker width limits
  assign sw_cycle_out = gate_a_en_in && (phase_cnt < 3'h2);
endmodule : pbm_stage_model

// [verification/pbm_phase_burst_manager_tb.sv]
// Testbench for the phase and burst manager: mode sequences on level ports.
// Assumes the design files and the stage model are compiled before it.
`timescale 1ns/1ps
module pbm_phase_burst_manager_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic below_shed = 1'b0, above_shed_hyst = 1'b0, below_burst = 1'b0;
  logic above_burst_hyst = 1'b0, line_high = 1'b0, sense_low = 1'b1;
  logic sense_ok = 1'b0, half_cycle = 1'b0, shed_low = 1'b0;
  logic [11:0] ton_cmd = 12'h100, ton_max = 12'h180, ton_a;
  logic shed_below_burst, sw_cycle, gate_a, gate_b, single;
  logic shed_cur, burst_cur, discharge, standby;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  pbm_phase_burst_manager i_pbm_phase_burst_manager (
    .REF_CLK_IN(ref_clk), .NRST_IN(nrst), .BELOW_SHED_IN(below_shed),
    .ABOVE_SHED_HYST_IN(above_shed_hyst), .BELOW_BURST_IN(below_burst),
    .ABOVE_BURST_HYST_IN(above_burst_hyst), .SHED_BELOW_BURST_IN(shed_below_burst),
    .LINE_HIGH_IN(line_high), .SENSE_LOW_IN(sense_low), .SENSE_REG_OK_IN(sense_ok),
    .HALF_CYCLE_IN(half_cycle), .SW_CYCLE_IN(sw_cycle), .TON_CMD_IN(ton_cmd),
    .TON_MAX_IN(ton_max), .TON_A_OUT(ton_a), .GATE_A_EN_OUT(gate_a),
    .GATE_DRIVE_SECOND_EN_OUT(gate_b), .SINGLE_PHASE_OUT(single),
    .SHED_RANGE_CURRENT_OUT(shed_cur), .BURST_RANGE_CURRENT_OUT(burst_cur),
    .COMP_DISCHARGE_OUT(discharge), .STANDBY_OUT(standby));
  pbm_stage_model i_pbm_stage_model (
    .ref_clk_in(ref_clk), .nrst_in(nrst), .gate_a_en_in(gate_a), .shed_low_in(shed_low),
    .sw_cycle_out(sw_cycle), .shed_below_burst_out(shed_below_burst));
  // 100 MHz core clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Ceiling well above the roughly 700 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Inputs change on falling edges only
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  // Marker held 3 clocks each way, above the 2-clock minimum
  task automatic half_pulses(input int n);
    repeat (n) begin
      half_cycle = 1'b1;
      idle(3);
      half_cycle = 1'b0;
      idle(3);
    end
  endtask : half_pulses
  initial begin
    idle(3);
    check("standby", 12'(standby), 12'h001);
    check("discharge", 12'(discharge), 12'h001);
    nrst = 1'b1;
    idle(2);
    check("gate a", 12'(gate_a), 12'h000);
    $display("test reset done");
    sense_low = 1'b0;
    below_shed = 1'b1;
    idle(8);
    check("standby", 12'(standby), 12'h000);
    check("gate a", 12'(gate_a), 12'h001);
    check("gate b", 12'(gate_b), 12'h001);
    check("single", 12'(single), 12'h000);
    $display("test soft start done");
    sense_ok = 1'b1;
    idle(6);
    half_pulses(10);
    below_shed = 1'b0;
    above_shed_hyst = 1'b1;
    idle(6);
    above_shed_hyst = 1'b0;
    below_shed = 1'b1;
    idle(6);
    half_pulses(13);
    check("single", 12'(single), 12'h000);
    half_pulses(1);
    idle(6);
    check("single", 12'(single), 12'h001);
    check("gate b", 12'(gate_b), 12'h000);
    check("ton a", ton_a, 12'h180);
    below_shed = 1'b0;
    idle(6);
    check("single", 12'(single), 12'h001);
    above_shed_hyst = 1'b1;
    idle(5);
    check("gate b", 12'(gate_b), 12'h001);
    check("ton a", ton_a, 12'h100);
    $display("test shedding done");
    line_high = 1'b1;
    idle(6);
    check("shed current", 12'(shed_cur), 12'h001);
    check("burst current", 12'(burst_cur), 12'h001);
    $display("test range done");
    above_shed_hyst = 1'b0;
    below_burst = 1'b1;
    idle(20);
    check("single", 12'(single), 12'h001);
    check("gate a", 12'(gate_a), 12'h001);
    idle(100);
    check("gate a", 12'(gate_a), 12'h000);
    check("gate b", 12'(gate_b), 12'h000);
    check("ton a", ton_a, 12'h000);
    below_burst = 1'b0;
    idle(10);
    check("gate a", 12'(gate_a), 12'h000);
    above_burst_hyst = 1'b1;
    idle(20);
    check("gate a", 12'(gate_a), 12'h001);
    check("ramp low", 12'(ton_a < 12'h100), 12'h001);
    idle(100);
    check("ton a", ton_a, 12'h100);
    $display("test burst done");
    shed_low = 1'b1;
    above_burst_hyst = 1'b0;
    below_burst = 1'b1;
    idle(120);
    check("gate a", 12'(gate_a), 12'h000);
    below_burst = 1'b0;
    above_burst_hyst = 1'b1;
    idle(20);
    check("single", 12'(single), 12'h001);
    check("gate b", 12'(gate_b), 12'h000);
    idle(100);
    check("single", 12'(single), 12'h000);
    check("gate b", 12'(gate_b), 12'h001);
    shed_low = 1'b0;
    $display("test ramp single done");
    sense_low = 1'b1;
    idle(6);
    check("standby", 12'(standby), 12'h001);
    check("discharge", 12'(discharge), 12'h001);
    check("gate a", 12'(gate_a), 12'h000);
    $display("test disable done");
    give_verdict();
  end
endmodule : pbm_phase_burst_manager_tb
